// >>> verilog/tcim_top.sv
// interrupt mask, event status and line mirrors of one timer channel
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ns
`default_nettype none
module tcim_top
  import tcim_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  // apb slave
  input  wire logic       psel,
  input  wire logic       penable,
  input  wire logic       pwrite,
  input  wire logic [7:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic            pready,
  output logic            pslverr,
  // counter core events, one-cycle strobes
  input  wire tcim_evt_t  evtStrobe,
  // driven line levels in waveform mode
  input  wire logic       driveLineA,
  input  wire logic       driveLineB,
  // timer line pins
  input  wire logic       timerLineA,
  input  wire logic       timerLineB,
  // mode and interrupt
  output logic            waveMode,
  output logic            irq
);
  logic [1:0] pinSync;
  logic [7:0] irqMask;
  logic [7:0] evtFlags;
  logic [7:0] next_flags;
  logic [7:0] next_mask;
  logic [7:0] evtValid;
  logic       lineAMirror;
  logic       lineBMirror;
  logic       apbWrite;
  logic       apbRead;
  logic       statusRead;
  logic       mapped;
  logic       apbSetup;

  tcim_sync #(
    .WIDTH (2)
  ) u_sync (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .din     ({timerLineB, timerLineA}),
    .dout    (pinSync)
  );

  // access phase; answer one cycle after setup
  assign apbSetup   = psel && !penable;
  assign apbWrite   = psel && penable && pwrite && pready;
  assign apbRead    = psel && penable && !pwrite && pready;
  assign statusRead = apbRead && (paddr == OFS_STATUS);
  assign mapped     = (paddr == OFS_STATUS) || (paddr == OFS_ENABLE) ||
                      (paddr == OFS_DISABLE) || (paddr == OFS_MASK) || (paddr == OFS_MODE);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
    end else begin
      pready <= apbSetup;
    end
  end

  a_ready_setup: assert property (@(posedge ref_clk) disable iff (!nrst) // see R5
    apbSetup
    |=> pready)
    else $error("ready missing after setup");

  a_ready_pulse: assert property (@(posedge ref_clk) disable iff (!nrst) // see R5
    pready
    |=> !pready)
    else $error("ready held longer than one cycle");

  a_ready_only: assert property (@(posedge ref_clk) disable iff (!nrst) // see R5
    pready
    |-> $past(apbSetup))
    else $error("ready without setup");

  // mode select register, 0 capture, 1 waveform
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      waveMode <= 1'b0;
    end else if (apbWrite && paddr == OFS_MODE) begin
      waveMode <= pwdata[0];
    end
  end

  a_mode_write: assert property (@(posedge ref_clk) disable iff (!nrst) // see R8
    (apbWrite && paddr == OFS_MODE)
    |=> (waveMode == $past(pwdata[0])))
    else $error("mode write not taken");

  a_mode_hold: assert property (@(posedge ref_clk) disable iff (!nrst) // see R7
    !(apbWrite && paddr == OFS_MODE)
    |=> $stable(waveMode))
    else $error("mode changed without write");

  // mode gating of sources
  assign evtValid = evtStrobe & (waveMode ? ~CAPT_ONLY : ~WAVE_ONLY); // see R7 see R8

  a_capt_valid: assert property (@(posedge ref_clk) disable iff (!nrst) // see R8
    !waveMode
    |-> ((evtValid & WAVE_ONLY) == 8'h00))
    else $error("compare source passed in capture");

  a_wave_valid: assert property (@(posedge ref_clk) disable iff (!nrst) // see R7
    waveMode
    |-> ((evtValid & CAPT_ONLY) == 8'h00))
    else $error("capture source passed in waveform");

  a_ovf_both: assert property (@(posedge ref_clk) disable iff (!nrst) // see R8
    evtStrobe.overflow
    |-> evtValid[BIT_OVF])
    else $error("overflow source blocked");

  a_cmpc_both: assert property (@(posedge ref_clk) disable iff (!nrst) // see R8
    evtStrobe.compareC
    |-> evtValid[BIT_CMPC])
    else $error("compare c source blocked");

  a_etrg_both: assert property (@(posedge ref_clk) disable iff (!nrst) // see R8
    evtStrobe.extTrigger
    |-> evtValid[BIT_ETRG])
    else $error("trigger source blocked");

  a_capt_pass: assert property (@(posedge ref_clk) disable iff (!nrst) // see R7
    (!waveMode && evtStrobe.loadA)
    |-> evtValid[BIT_LDA])
    else $error("load a source blocked in capture");

  a_wave_pass: assert property (@(posedge ref_clk) disable iff (!nrst) // see R8
    (waveMode && evtStrobe.compareA)
    |-> evtValid[BIT_CMPA])
    else $error("compare a source blocked in waveform");

  // enable sets, disable clears
  always_comb begin
    next_mask = irqMask;
    if (apbWrite && paddr == OFS_ENABLE) begin
      next_mask = irqMask | pwdata[NUM_EVT-1:0]; // see R3 see R6
    end else if (apbWrite && paddr == OFS_DISABLE) begin
      next_mask = irqMask & ~pwdata[NUM_EVT-1:0]; // see R4 see R6
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irqMask <= MASK_RESET;
    end else begin
      irqMask <= next_mask;
    end
  end

  a_mask_enable: assert property (@(posedge ref_clk) disable iff (!nrst) // see R3
    (apbWrite && paddr == OFS_ENABLE)
    |=> ((irqMask & $past(pwdata[7:0])) == $past(pwdata[7:0])))
    else $error("enable write did not set mask");

  a_mask_keep_en: assert property (@(posedge ref_clk) disable iff (!nrst) // see R3
    (apbWrite && paddr == OFS_ENABLE)
    |=> ((irqMask & ~$past(pwdata[7:0])) == ($past(irqMask) & ~$past(pwdata[7:0]))))
    else $error("enable write changed unselected mask bits");

  a_mask_disable: assert property (@(posedge ref_clk) disable iff (!nrst) // see R4
    (apbWrite && paddr == OFS_DISABLE)
    |=> ((irqMask & $past(pwdata[7:0])) == 8'h00))
    else $error("disable write did not clear mask");

  a_mask_keep_dis: assert property (@(posedge ref_clk) disable iff (!nrst) // see R4
    (apbWrite && paddr == OFS_DISABLE)
    |=> ((irqMask & ~$past(pwdata[7:0])) == ($past(irqMask) & ~$past(pwdata[7:0]))))
    else $error("disable write changed unselected mask bits");

  a_mask_hold: assert property (@(posedge ref_clk) disable iff (!nrst) // see R6
    !(apbWrite && (paddr == OFS_ENABLE || paddr == OFS_DISABLE))
    |=> $stable(irqMask))
    else $error("mask changed without write");

  // read clears only the flags it reported, new event wins
  always_comb begin
    next_flags = statusRead ? (evtFlags & ~prdata[NUM_EVT-1:0]) : evtFlags;
    next_flags = next_flags | evtValid; // see R9
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      evtFlags <= 8'h00;
    end else begin
      evtFlags <= next_flags;
    end
  end

  a_flag_set: assert property (@(posedge ref_clk) disable iff (!nrst) // see R9
    evtValid[BIT_CMPC]
    |=> evtFlags[BIT_CMPC])
    else $error("event did not set flag");

  a_flag_all: assert property (@(posedge ref_clk) disable iff (!nrst) // see R9
    (evtValid != 8'h00)
    |=> ((evtFlags & $past(evtValid)) == $past(evtValid)))
    else $error("event lost its flag");

  a_flag_clear: assert property (@(posedge ref_clk) disable iff (!nrst) // see R9
    statusRead
    |=> ((evtFlags & $past(prdata[7:0]) & ~$past(evtValid)) == 8'h00))
    else $error("status read did not clear reported flags");

  a_flag_keep: assert property (@(posedge ref_clk) disable iff (!nrst) // see R9
    statusRead
    |=> ((evtFlags & $past(evtFlags) & ~$past(prdata[7:0])) == ($past(evtFlags) & ~$past(prdata[7:0]))))
    else $error("status read dropped an unreported flag");

  a_flag_hold: assert property (@(posedge ref_clk) disable iff (!nrst) // see R9
    !statusRead
    |=> ((evtFlags & $past(evtFlags)) == $past(evtFlags)))
    else $error("flag dropped without status read");

  a_flag_source: assert property (@(posedge ref_clk) disable iff (!nrst) // see R9
    1'b1
    |=> ((evtFlags & ~$past(evtFlags) & ~$past(evtValid)) == 8'h00))
    else $error("flag set without event");

  a_capt_gate: assert property (@(posedge ref_clk) disable iff (!nrst) // see R7
    (waveMode && !statusRead)
    |=> ((evtFlags & CAPT_ONLY) == ($past(evtFlags) & CAPT_ONLY)))
    else $error("capture source flagged in waveform");

  a_wave_gate: assert property (@(posedge ref_clk) disable iff (!nrst) // see R8
    (!waveMode && !statusRead)
    |=> ((evtFlags & WAVE_ONLY) == ($past(evtFlags) & WAVE_ONLY)))
    else $error("compare source flagged in capture");

  // line mirrors
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lineAMirror <= 1'b0;
      lineBMirror <= 1'b0;
    end else begin
      lineAMirror <= waveMode ? driveLineA : pinSync[0]; // see R1
      lineBMirror <= waveMode ? driveLineB : pinSync[1]; // see R2
    end
  end

  a_mirror_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see R1
    (waveMode && $past(waveMode))
    |-> (lineAMirror == $past(driveLineA)))
    else $error("line a mirror wrong in waveform");

  a_mirror_a_pin: assert property (@(posedge ref_clk) disable iff (!nrst) // see R1
    (!waveMode && !$past(waveMode))
    |-> (lineAMirror == $past(pinSync[0])))
    else $error("line a mirror wrong in capture");

  a_mirror_b: assert property (@(posedge ref_clk) disable iff (!nrst) // see R2
    (!waveMode && !$past(waveMode))
    |-> (lineBMirror == $past(pinSync[1])))
    else $error("line b mirror wrong in capture");

  a_mirror_b_drive: assert property (@(posedge ref_clk) disable iff (!nrst) // see R2
    (waveMode && $past(waveMode))
    |-> (lineBMirror == $past(driveLineB)))
    else $error("line b mirror wrong in waveform");

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_flags & next_mask); // see R10
    end
  end

  a_irq_level: assert property (@(posedge ref_clk) disable iff (!nrst) // see R10
    irq
    == (|(evtFlags & irqMask)))
    else $error("irq level mismatch");

  // read data, registered in setup cycle
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (apbSetup) begin
      prdata  <= 32'h0000_0000;
      pslverr <= !mapped;
      if (!pwrite) begin
        unique case (paddr)
          OFS_STATUS: begin
            prdata[NUM_EVT-1:0] <= evtFlags;
            prdata[BIT_MIRA]    <= lineAMirror;
            prdata[BIT_MIRB]    <= lineBMirror;
          end
          OFS_MASK: begin
            prdata[NUM_EVT-1:0] <= irqMask; // see R5
          end
          OFS_MODE: begin
            prdata[0] <= waveMode;
          end
          default: begin
            prdata <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  a_mask_read: assert property (@(posedge ref_clk) disable iff (!nrst) // see R5
    (apbSetup && !pwrite && paddr == OFS_MASK)
    |=> (prdata[7:0] == $past(irqMask)))
    else $error("mask readback wrong");

  a_status_read: assert property (@(posedge ref_clk) disable iff (!nrst) // see R9
    (apbSetup && !pwrite && paddr == OFS_STATUS)
    |=> (prdata[7:0] == $past(evtFlags)))
    else $error("status readback wrong");

  a_mirror_read: assert property (@(posedge ref_clk) disable iff (!nrst) // see R1 see R2
    (apbSetup && !pwrite && paddr == OFS_STATUS)
    |=> (prdata[BIT_MIRB:BIT_MIRA] == {$past(lineBMirror), $past(lineAMirror)}))
    else $error("mirror readback wrong");

  a_upper_zero: assert property (@(posedge ref_clk) disable iff (!nrst) // see R6
    (apbSetup && !pwrite && paddr == OFS_MASK)
    |=> (prdata[31:8] == 24'h000000))
    else $error("mask upper bits not zero");

  a_wo_read: assert property (@(posedge ref_clk) disable iff (!nrst) // see R3
    (apbSetup && !pwrite && (paddr == OFS_ENABLE || paddr == OFS_DISABLE))
    |=> (prdata == 32'h0000_0000))
    else $error("write-only register read not zero");

  a_slverr_map: assert property (@(posedge ref_clk) disable iff (!nrst) // see R5
    apbSetup
    |=> (pslverr == !$past(mapped)))
    else $error("slave error does not match address map");

  a_rdata_stand: assert property (@(posedge ref_clk) disable iff (!nrst) // see R5
    !apbSetup
    |=> $stable(prdata))
    else $error("read data changed outside setup");
endmodule
`default_nettype wire

// >>> verilog/tcim_pkg.sv
// constants and types for the timer channel interrupt mask logic
//
// Overview of operation
// R1: status bit 16 mirrors line a: pin in capture mode, driven level in waveform.
// R2: status bit 17 mirrors line b: pin in capture mode, driven level in waveform.
// R3: writing ones to the enable register sets those mask bits, zeros no effect.
// R4: writing ones to the disable register clears those mask bits, zeros no effect.
// R5: mask register reads one for each enabled source, zero otherwise.
// R6: enable, disable, mask share bits 0..7 in the fixed event order.
// R7: load overrun and both capture loads only apply in capture mode.
// R8: compares a and b only apply in waveform mode; others in both.
// R9: event flags set on events and clear when the status register is read.
// R10: interrupt output high while any flag with its mask bit set remains.
package tcim_pkg;
  localparam logic [7:0]  OFS_STATUS  = 8'h20;
  localparam logic [7:0]  OFS_ENABLE  = 8'h24;
  localparam logic [7:0]  OFS_DISABLE = 8'h28;
  localparam logic [7:0]  OFS_MASK    = 8'h2c;
  localparam logic [7:0]  OFS_MODE    = 8'h04;
  localparam int          NUM_EVT     = 8;
  localparam int          BIT_OVF     = 0;
  localparam int          BIT_LOVR    = 1;
  localparam int          BIT_CMPA    = 2;
  localparam int          BIT_CMPB    = 3;
  localparam int          BIT_CMPC    = 4;
  localparam int          BIT_LDA     = 5;
  localparam int          BIT_LDB     = 6;
  localparam int          BIT_ETRG    = 7;
  localparam int          BIT_MIRA    = 16;
  localparam int          BIT_MIRB    = 17;
  localparam logic [7:0]  MASK_RESET  = 8'h00;
  localparam logic [7:0]  CAPT_ONLY   = 8'h62;
  localparam logic [7:0]  WAVE_ONLY   = 8'h0c;

  typedef struct packed {
    logic extTrigger;
    logic loadB;
    logic loadA;
    logic compareC;
    logic compareB;
    logic compareA;
    logic loadOverrun;
    logic overflow;
  } tcim_evt_t;
endpackage

// >>> verilog/tcim_sync.sv
// two-stage synchroniser for the timer line pins
`timescale 1ns/1ns
`default_nettype none
module tcim_sync
  import tcim_pkg::*;
#(
  parameter int WIDTH = 2
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             nrst,
  // data
  input  wire logic [WIDTH-1:0] din,
  output var  logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      stage1 <= '0;
      dout   <= '0;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/tcim_top_tb_top.sv
// self-checking bench for the timer channel interrupt mask logic
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, s) begin check_count++; if ((s) !== (e)) begin n_errors++; \
  $display("Error %s expected %h seen %h", nm, e, s); end end
module tcim_top_tb_top
  import tcim_pkg::*;
;
  logic        ref_clk = 0;
  logic        nrst = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  tcim_evt_t   evtStrobe = '0;
  logic        driveLineA = 0;
  logic        driveLineB = 0;
  logic        timerLineA = 0;
  logic        timerLineB = 0;
  logic        waveMode;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  int          n_errors = 0;
  int          check_count = 0;

  tcim_top tcim_top_inst (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .evtStrobe(evtStrobe),
    .driveLineA(driveLineA), .driveLineB(driveLineB), .timerLineA(timerLineA), .timerLineB(timerLineB),
    .waveMode(waveMode), .irq(irq));

  always #25 ref_clk = ~ref_clk;

  // one apb transfer, entered and left just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic pulse(input tcim_evt_t e);
    evtStrobe <= e;
    @(posedge ref_clk);
    evtStrobe <= '0;
    @(posedge ref_clk);
  endtask

  task automatic mask_test();
    apb(0, OFS_MASK, 0);
    `CHK("mask reset", MASK_RESET, rd[7:0])
    apb(1, OFS_ENABLE, 32'h0000_00a5);
    apb(1, OFS_ENABLE, 32'h0000_0000);
    apb(0, OFS_MASK, 0);
    `CHK("mask set", 32'h0000_00a5, rd)
    apb(1, OFS_DISABLE, 32'h0000_0021);
    apb(1, OFS_DISABLE, 32'h0000_0000);
    apb(0, OFS_MASK, 0);
    `CHK("mask clear", 32'h0000_0084, rd)
  endtask

  task automatic capture_test();
    pulse(8'hff);
    `CHK("irq capture", 1'b1, irq)
    apb(0, OFS_STATUS, 0);
    `CHK("flags capture", 8'hf3, rd[7:0])
    `CHK("irq cleared", 1'b0, irq)
    apb(0, OFS_STATUS, 0);
    `CHK("flags after read", 8'h00, rd[7:0])
  endtask

  task automatic wave_test();
    apb(1, OFS_MODE, 32'h0000_0001);
    `CHK("wave mode", 1'b1, waveMode)
    pulse(8'hff);
    `CHK("irq wave", 1'b1, irq)
    apb(1, OFS_DISABLE, 32'h0000_00ff);
    `CHK("irq masked", 1'b0, irq)
    apb(0, OFS_STATUS, 0);
    `CHK("flags wave", 8'h9d, rd[7:0])
  endtask

  // events in the setup and in the access cycle of a status read
  task automatic race_test();
    fork
      apb(0, OFS_STATUS, 0);
      pulse(8'h01);
    join
    `CHK("flag before read", 8'h00, rd[7:0])
    fork
      apb(0, OFS_STATUS, 0);
      begin
        @(posedge ref_clk);
        pulse(8'h10);
      end
    join
    `CHK("flag kept", 8'h01, rd[7:0])
    apb(0, OFS_STATUS, 0);
    `CHK("flag set wins", 8'h10, rd[7:0])
  endtask

  task automatic mirror_test();
    driveLineA <= 1'b1;
    driveLineB <= 1'b0;
    repeat (2) @(posedge ref_clk);
    apb(0, OFS_STATUS, 0);
    `CHK("mirror wave", 2'b01, rd[BIT_MIRB:BIT_MIRA])
    apb(1, OFS_MODE, 32'h0000_0000);
    timerLineA <= 1'b0;
    timerLineB <= 1'b1;
    repeat (5) @(posedge ref_clk);
    apb(0, OFS_STATUS, 0);
    `CHK("mirror capture", 2'b10, rd[BIT_MIRB:BIT_MIRA])
  endtask

  task automatic unmapped_test();
    apb(0, 8'h30, 0);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0000_0000, rd)
    apb(1, OFS_MASK, 32'h0000_00ff);
    apb(0, OFS_MASK, 0);
    `CHK("mask read only", 32'h0000_0000, rd)
    apb(0, OFS_ENABLE, 0);
    `CHK("enable read zero", 32'h0000_0000, rd)
    `CHK("enable read err", 1'b0, err)
  endtask

  task automatic stop_test();
    if (n_errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    mask_test();
    capture_test();
    wave_test();
    race_test();
    mirror_test();
    unmapped_test();
    stop_test();
  end

  initial begin
    #200000;
    n_errors++;
    stop_test();
  end
endmodule
`default_nettype wire
